/* File: logic/secl_defines.svh */
// Purpose: constants of the serial memory configuration loader
// Assumes: core clock of 200 MHz, link rate of 1 Mb/s
// Notes:   offsets of config words are the memory word addresses
`ifndef SECL_DEFINES_SVH
`define SECL_DEFINES_SVH

// core clock period and link bit time, in ns
`define SECL_CLK_NS    5
`define SECL_BIT_NS    1000
// half bit is a least time, so it rounds up to whole cycles
`define SECL_HALF_CYC  (((`SECL_BIT_NS / 2) + `SECL_CLK_NS - 1) / `SECL_CLK_NS)

// read command: start bit, two-bit opcode
`define SECL_START_BIT 1'h1
`define SECL_OP_READ   2'h2
`define SECL_CMD_HDR_W 3

// memory geometry: 16-bit words
`define SECL_WORD_W    16
`define SECL_WORDS     64
`define SECL_ADDR_W    6

// image is valid when the xor of all words with this seed is zero
`define SECL_CSUM_SEED 16'haaaa

`endif

/* File: logic/secl_pkg.sv */
// Purpose: types shared by the configuration loader files
// Assumes: nothing beyond the defines header
// Notes:   pin bundle travels as one packed struct
package secl_pkg;

  // what the loader drives onto the three memory pins
  typedef struct packed {
    logic cs;
    logic sk;
    logic dout;
    logic doe_n;
  } secl_pins_t;

  typedef enum logic [1:0] {
    SECL_LK_IDLE = 2'b00,
    SECL_LK_LOW  = 2'b01,
    SECL_LK_HIGH = 2'b10,
    SECL_LK_END  = 2'b11
  } secl_link_st_t;

  typedef enum logic [1:0] {
    SECL_ST_START = 2'b00,
    SECL_ST_READ  = 2'b01,
    SECL_ST_DONE  = 2'b10
  } secl_top_st_t;

endpackage

/* File: logic/secl_link.sv */
// Purpose: one read transaction on the three-wire serial memory link
// Assumes: data_in already synchronised to clk
// Notes:   one bit per two half periods, data sampled before rising sk
`timescale 1ns/100ps
`include "secl_defines.svh"

module secl_link
  import secl_pkg::*;
#(
  parameter int ADDR_W = `SECL_ADDR_W,
  parameter int HALF   = `SECL_HALF_CYC
)
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    start,
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire logic                    data_in,
  output logic                         busy,
  output logic                         done,
  output logic                         ack_ok,
  output logic [`SECL_WORD_W-1:0]      word,
  output secl_pins_t                   pins
);

  localparam int CMD_BITS = `SECL_CMD_HDR_W + ADDR_W;
  // one ack sample, then sixteen data bits
  localparam int TOTAL    = CMD_BITS + 1 + `SECL_WORD_W;
  localparam int A_HI     = HALF - 1;

  // the data pin passes two sync stages and the pin register, so a low
  // half shorter than four cycles would sample the line before it settles
  initial
  begin
    if (HALF < 4 || HALF > 65535 || TOTAL > 255)
      $error("secl_link: unsupported HALF or ADDR_W");
  end

  secl_link_st_t       state;
  logic [15:0]         ctr;
  logic [7:0]          bit_idx;
  logic [CMD_BITS-1:0] cmd;
  logic                half_end;

  assign half_end = (ctr == 16'(HALF - 1));
  assign busy     = (state != SECL_LK_IDLE);

  // half period timer, restarts at every phase change
  always_ff @(posedge clk)
  begin
    if (rst || state == SECL_LK_IDLE || half_end)
      ctr <= 16'h0;
    else
      ctr <= ctr + 16'h1;
  end

  // bit sequencer and pin drive
  always_ff @(posedge clk)
  begin
    done <= 1'b0;
    if (rst)
    begin
      state   <= SECL_LK_IDLE;
      bit_idx <= 8'h0;
      cmd     <= '0;
      pins    <= '{cs: 1'b0, sk: 1'b0, dout: 1'b1, doe_n: 1'b1};
    end
    else
    begin
      unique case (state)
        SECL_LK_IDLE:
        begin
          if (start)
          begin
            // select, start bit one, read opcode, address
            cmd        <= {`SECL_START_BIT, `SECL_OP_READ, addr};
            pins.cs    <= 1'b1;
            pins.dout  <= `SECL_START_BIT;
            pins.doe_n <= 1'b0;
            bit_idx    <= 8'h0;
            state      <= SECL_LK_LOW;
          end
        end
        SECL_LK_LOW:
        begin
          if (half_end)
          begin
            pins.sk <= 1'b1; // memory latches on this edge
            state   <= SECL_LK_HIGH;
          end
        end
        SECL_LK_HIGH:
        begin
          if (half_end)
          begin
            pins.sk <= 1'b0;
            bit_idx <= bit_idx + 8'h1;
            cmd     <= {cmd[CMD_BITS-2:0], 1'b0};
            if (bit_idx == 8'(TOTAL - 1))
            begin
              pins.cs <= 1'b0;
              state   <= SECL_LK_END;
            end
            else
            begin
              state <= SECL_LK_LOW;
              if (bit_idx + 8'h1 < 8'(CMD_BITS))
                pins.dout <= cmd[CMD_BITS-2];
              else
              begin
                // same pin now listens; series resistor covers overlap
                pins.dout  <= 1'b1;
                pins.doe_n <= 1'b1;
              end
            end
          end
        end
        SECL_LK_END:
        begin
          // keep select low for a half period before the next read
          if (half_end)
          begin
            done  <= 1'b1;
            state <= SECL_LK_IDLE;
          end
        end
      endcase
    end
  end

  // sample just before each rising sk once the command is out
  always_ff @(posedge clk)
  begin
    if (rst || (state == SECL_LK_IDLE && start))
    begin
      ack_ok <= 1'b0;
      word   <= '0;
    end
    else if (state == SECL_LK_LOW && half_end && bit_idx >= 8'(CMD_BITS))
    begin
      if (bit_idx == 8'(CMD_BITS))
        ack_ok <= ~data_in; // high line means no memory or bad command
      else
        word <= {word[`SECL_WORD_W-2:0], data_in}; // msb first
    end
  end

  sequence s_cmd_open;
    pins.cs && pins.dout && !pins.doe_n && !pins.sk;
  endsequence

  // low half lasts HALF sampled cycles, so sk is first seen high HALF later
  sequence s_first_rise;
    ##HALF pins.sk;
  endsequence

  a_cmd_start_bit: assert property (@(posedge clk) disable iff (rst)
    (state == SECL_LK_IDLE && start) |=> s_cmd_open ##0 s_first_rise)
    else $error("read did not open with select and start bit");

  a_clock_high_half: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.sk) |-> pins.cs ##A_HI pins.sk ##1 !pins.sk)
    else $error("serial clock high half has wrong length");

  a_data_released: assert property (@(posedge clk) disable iff (rst)
    (busy && bit_idx >= 8'(CMD_BITS)) |-> pins.doe_n)
    else $error("data pin driven while memory answers");

  a_ack_high_fails: assert property (@(posedge clk) disable iff (rst)
    (state == SECL_LK_LOW && half_end && bit_idx == 8'(CMD_BITS)
     && data_in) |=> !ack_ok ##1 !ack_ok)
    else $error("high ack line accepted");

  a_word_bits: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.cs) |-> bit_idx == 8'(TOTAL))
    else $error("transaction did not carry sixteen data bits");

endmodule

/* File: logic/secl_loader.sv */
// Purpose: power-up configuration loader from a serial 16-bit memory
// Assumes: ext_rst_n and memory_data_in are asynchronous pins
// Notes:   pins float (oe_n high) while ext_rst_n is low
//
// Contract
// - After power-on reset and every USB reset the memory is read.
// - Stored data is used only if present and valid, else defaults.
// - A high data line at acknowledge means bad command or no memory.
// - Memory is 16-bit organised and read in whole 16-bit words.
// - While the external reset is low the three pins are released.
// - The loader drives select and clock as sole link master.
// - One data pin sends command bits and samples the memory output.
`timescale 1ns/100ps
`include "secl_defines.svh"

module secl_loader
  import secl_pkg::*;
#(
  parameter int                      WORDS       = `SECL_WORDS,
  parameter int                      ADDR_W      = `SECL_ADDR_W,
  parameter int                      HALF        = `SECL_HALF_CYC,
  parameter logic [16*WORDS-1:0]     DEFAULT_CFG = '0
)
(
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ext_rst_n,
  input  wire logic                  usb_reset,
  input  wire logic                  memory_data_in,
  output logic                       memory_select_out,
  output logic                       memory_select_oe_n,
  output logic                       memory_clock_out,
  output logic                       memory_clock_oe_n,
  output logic                       memory_data_out,
  output logic                       memory_data_oe_n,
  output logic [16*WORDS-1:0]        cfg_words,
  output logic                       cfg_ready,
  output logic                       cfg_from_memory,
  output logic                       memory_present
);

  localparam int W = `SECL_WORD_W;

  initial
  begin
    if (WORDS < 2 || WORDS > (1 << ADDR_W) || W != 16)
      $error("secl_loader: WORDS does not fit the address width");
  end

  logic              rst_meta;
  logic              rst_sync;
  logic              din_meta;
  logic              din_sync;
  logic              held;
  logic              link_rst;
  logic              link_start;
  logic              link_busy;
  logic              link_done;
  logic              link_ack;
  logic [W-1:0]      link_word;
  secl_pins_t        pins;
  secl_top_st_t      state;
  logic [ADDR_W-1:0] idx;
  logic [W-1:0]      csum;
  logic [W-1:0]      next_csum;
  logic              got_word;
  logic              last_word;
  logic              load_def;

  // two-stage synchronisers; only the second stage is read
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
      din_meta <= 1'b1;
      din_sync <= 1'b1;
    end
    else
    begin
      rst_meta <= ext_rst_n;
      rst_sync <= rst_meta;
      din_meta <= memory_data_in;
      din_sync <= din_meta;
    end
  end

  assign held = ~rst_sync;

  // link is aborted by any reset so a fresh scan always starts clean
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      link_rst <= 1'b1;
    else
      link_rst <= held | usb_reset;
  end

  secl_link #(
    .ADDR_W (ADDR_W),
    .HALF   (HALF)
  ) u_link (
    .clk     (core_clk),
    .rst     (link_rst),
    .start   (link_start),
    .addr    (idx),
    .data_in (din_sync),
    .busy    (link_busy),
    .done    (link_done),
    .ack_ok  (link_ack),
    .word    (link_word),
    .pins    (pins)
  );

  assign got_word  = (state == SECL_ST_READ) && link_done && link_ack;
  assign last_word = (idx == ADDR_W'(WORDS - 1));
  assign next_csum = csum ^ link_word;
  // defaults on missing ack or on a bad image at the last word
  assign load_def  = (state == SECL_ST_READ) && link_done &&
                     (!link_ack || (last_word && next_csum != '0));

  // scan sequencer; restarts on every power-on or USB reset
  always_ff @(posedge core_clk)
  begin
    link_start <= 1'b0;
    if (sys_rst || held || usb_reset || link_rst)
    begin
      state <= SECL_ST_START;
      idx   <= '0;
      csum  <= `SECL_CSUM_SEED;
    end
    else
    begin
      unique case (state)
        SECL_ST_START:
        begin
          if (!link_busy)
          begin
            link_start <= 1'b1;
            state      <= SECL_ST_READ;
          end
        end
        SECL_ST_READ:
        begin
          if (link_done)
          begin
            if (!link_ack || last_word)
              state <= SECL_ST_DONE;
            else
            begin
              csum  <= next_csum;
              idx   <= idx + ADDR_W'(1);
              state <= SECL_ST_START;
            end
          end
        end
        SECL_ST_DONE:
          state <= SECL_ST_DONE;
        default:
          state <= SECL_ST_START;
      endcase
    end
  end

  // result flags; consumers must wait for cfg_ready
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || held || usb_reset || link_rst)
    begin
      cfg_ready       <= 1'b0;
      cfg_from_memory <= 1'b0;
      memory_present  <= 1'b0;
    end
    else if ((state == SECL_ST_READ) && link_done &&
             (!link_ack || last_word))
    begin
      cfg_ready       <= 1'b1;
      memory_present  <= link_ack;
      cfg_from_memory <= !load_def;
    end
  end

  // one storage word per entry; words land as read, defaults overwrite
  genvar g;
  generate
    for (g = 0; g < WORDS; g++)
    begin : g_word
      always_ff @(posedge core_clk)
      begin
        if (sys_rst || load_def)
          cfg_words[g*W +: W] <= DEFAULT_CFG[g*W +: W];
        else if (got_word && idx == ADDR_W'(g))
          cfg_words[g*W +: W] <= link_word;
      end
    end
  endgenerate

  // pin stage; everything floats while the external reset is low
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || held)
    begin
      memory_select_out  <= 1'b0;
      memory_select_oe_n <= 1'b1;
      memory_clock_out   <= 1'b0;
      memory_clock_oe_n  <= 1'b1;
      memory_data_out    <= 1'b1;
      memory_data_oe_n   <= 1'b1;
    end
    else
    begin
      memory_select_out  <= pins.cs;
      memory_select_oe_n <= 1'b0;
      memory_clock_out   <= pins.sk;
      memory_clock_oe_n  <= 1'b0;
      memory_data_out    <= pins.dout;
      memory_data_oe_n   <= pins.doe_n;
    end
  end

  a_pins_released: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    held |=> memory_select_oe_n && memory_clock_oe_n && memory_data_oe_n)
    else $error("memory pins driven while held in reset");

  a_scan_on_release: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    $fell(held) |-> ##[1:4] link_start)
    else $error("no scan after external reset release");

  a_scan_on_usb: assert property (@(posedge core_clk)
    disable iff (sys_rst || held)
    $fell(usb_reset) |-> !cfg_ready ##[1:4] link_start)
    else $error("no rescan after USB reset");

  a_nack_defaults: assert property (@(posedge core_clk)
    disable iff (sys_rst || held || usb_reset)
    ((state == SECL_ST_READ) && link_done && !link_ack) |=>
      cfg_ready && !cfg_from_memory && !memory_present &&
      cfg_words == DEFAULT_CFG)
    else $error("absent memory did not give defaults");

  a_adopt_valid: assert property (@(posedge core_clk)
    disable iff (sys_rst || held || usb_reset)
    (got_word && last_word && next_csum == '0) |=>
      cfg_ready && cfg_from_memory && memory_present)
    else $error("valid image not adopted");

endmodule

/* File: tb/secl_mem_model.sv */
// Purpose: behavioural 16-bit word serial memory on the loader's link
// Assumes: cs and sk are the resolved wire levels, din the data wire
// Notes:   data line rests high on its pull-up whenever q is not driven
`timescale 1ns/100ps

module secl_mem_model
#(
  parameter int ADDR_W = 6
)
(
  input  wire logic              cs,
  input  wire logic              sk,
  input  wire logic              din,
  input  wire logic              present,
  input  wire logic [31:0]       image,
  output logic                   drive,
  output logic                   q,
  output logic [2:0]             hdr,
  output logic [ADDR_W-1:0]      addr
);
  int          cnt;
  logic [15:0] sh;
  logic [ADDR_W-1:0] a_full;

  initial
  begin
    cnt = 0;
    drive = 1'b0;
    q = 1'b1;
    hdr = 3'h0;
    addr = '0;
    sh = 16'h0000;
  end

  // bits are taken on rising sk; output moves on rising sk as well, so it
  // is settled for the whole following low half where the loader samples
  always @(posedge sk or negedge cs)
  begin
    if (!cs)
    begin
      cnt = 0;
      drive = 1'b0;
    end
    else
    begin
      a_full = {addr[ADDR_W-2:0], din};
      if (cnt < 3)
        hdr = {hdr[1:0], din};
      else if (cnt < 3 + ADDR_W)
        addr = a_full;
      // only a read header of start one, opcode one zero gets the ack
      if (cnt == 2 + ADDR_W && present && hdr == 3'h6)
      begin
        drive = 1'b1;
        q = 1'b0;
        sh = a_full[0] ? image[31:16] : image[15:0];
      end
      else if (cnt >= 3 + ADDR_W && drive)
      begin
        q = sh[15];
        sh = {sh[14:0], 1'b0};
      end
      cnt = cnt + 1;
    end
  end
endmodule

/* File: tb/test_secl_loader.sv */
// Purpose: self-checking bench of the serial memory configuration loader
// Assumes: short half bit and two words keep the run brief
// Notes:   bench plays the sharing controller on the external reset
`timescale 1ns/100ps

`define CHK(nm, e, g) \
  begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module test_secl_loader;
  import secl_pkg::*;
  localparam logic [31:0] DEF  = 32'h5a5a_0f0f;
  localparam logic [31:0] GOOD = 32'hb89e_1234; // xor with seed is zero
  localparam logic [31:0] BAD  = 32'hb89e_1235;

  logic        core_clk, sys_rst, ext_rst_n, usb_reset, present;
  logic        memory_data_in, m_drive, m_q;
  logic        sel, sel_oe_n, sk, sk_oe_n, dout, d_oe_n;
  logic [31:0] cfg_words, image;
  logic        cfg_ready, cfg_from_memory, memory_present;
  logic [2:0]  hdr;
  logic [5:0]  addr;
  int          n_mismatch, cmp_count, cycles;

  // the loader's own drive wins at its pin, the memory sits behind a resistor
  assign memory_data_in = !d_oe_n ? dout : (m_drive ? m_q : 1'b1);

  secl_loader #(.WORDS(2), .ADDR_W(6), .HALF(4), .DEFAULT_CFG(DEF))
    secl_loader_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .ext_rst_n(ext_rst_n), .usb_reset(usb_reset),
    .memory_data_in(memory_data_in), .memory_select_out(sel),
    .memory_select_oe_n(sel_oe_n), .memory_clock_out(sk),
    .memory_clock_oe_n(sk_oe_n), .memory_data_out(dout),
    .memory_data_oe_n(d_oe_n), .cfg_words(cfg_words),
    .cfg_ready(cfg_ready), .cfg_from_memory(cfg_from_memory),
    .memory_present(memory_present));

  secl_mem_model #(.ADDR_W(6)) secl_mem_model_inst (
    .cs(!sel_oe_n & sel), .sk(!sk_oe_n & sk), .din(memory_data_in),
    .present(present), .image(image), .drive(m_drive), .q(m_q),
    .hdr(hdr), .addr(addr));

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  // hang guard: a full scan is about 430 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      results();
    end
  end

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wait_ready();
    int i;
    for (i = 0; i < 2000 && cfg_ready !== 1'b1; i++)
      @(negedge core_clk);
    `CHK("cfg_ready", 1'b1, cfg_ready)
  endtask

  task automatic bus_reset();
    usb_reset = 1'b1;
    repeat (2) @(negedge core_clk);
    usb_reset = 1'b0;
  endtask

  // first scan after reset adopts a valid image
  task automatic t_valid();
    int i;
    for (i = 0; i < 100 && sel !== 1'b1; i++)
      @(negedge core_clk);
    `CHK("select", 1'b1, sel)
    `CHK("select_oe_n", 1'b0, sel_oe_n)
    `CHK("clock_oe_n", 1'b0, sk_oe_n)
    `CHK("data_oe_n", 1'b0, d_oe_n)
    wait_ready();
    `CHK("header", 3'h6, hdr)
    `CHK("last address", 6'h01, addr)
    `CHK("present", 1'b1, memory_present)
    `CHK("from memory", 1'b1, cfg_from_memory)
    `CHK("words", GOOD, cfg_words)
    $display("test valid image done");
  endtask

  // usb reset rescans; a bad image falls back to defaults
  task automatic t_bad_sum();
    image = BAD;
    bus_reset();
    wait_ready();
    `CHK("present", 1'b1, memory_present)
    `CHK("from memory", 1'b0, cfg_from_memory)
    `CHK("words", DEF, cfg_words)
    $display("test bad image done");
  endtask

  // no ack: line stays high on the pull-up
  task automatic t_absent();
    image = GOOD;
    present = 1'b0;
    bus_reset();
    wait_ready();
    `CHK("present", 1'b0, memory_present)
    `CHK("from memory", 1'b0, cfg_from_memory)
    `CHK("words", DEF, cfg_words)
    $display("test absent memory done");
  endtask

  // held in external reset the pins float, then a reload follows release
  task automatic t_ext_reset();
    ext_rst_n = 1'b0;
    repeat (6) @(negedge core_clk);
    `CHK("select_oe_n", 1'b1, sel_oe_n)
    `CHK("clock_oe_n", 1'b1, sk_oe_n)
    `CHK("data_oe_n", 1'b1, d_oe_n)
    `CHK("ready held", 1'b0, cfg_ready)
    present = 1'b1;
    repeat (20) @(negedge core_clk);
    ext_rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    wait_ready();
    `CHK("from memory", 1'b1, cfg_from_memory)
    `CHK("words", GOOD, cfg_words)
    $display("test external reset done");
  endtask

  initial
  begin
    n_mismatch = 0;
    cmp_count = 0;
    cycles = 0;
    sys_rst = 1'b1;
    ext_rst_n = 1'b1;
    usb_reset = 1'b0;
    present = 1'b1;
    image = GOOD;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    t_valid();
    t_bad_sum();
    t_absent();
    t_ext_reset();
    results();
  end
endmodule
